// [hdl/trs_timing_flag_insertion.sv]
// trs timing flag insertion: sets f, v and h of outgoing timing reference words
//
// Operation
// - with auto_timing_sense low, processing allowed and the trs mask control bit clear, a high h input sets the h bit of every outgoing trs word.
// - horizontal timing comes from the h input only while auto_timing_sense is low.
// - one control bit reachable from the host port picks the convention applied to the h input.
// - with auto_timing_sense low, processing allowed and the trs mask control bit clear, a high v input sets the v bit of every outgoing trs word.
// - the v input is ignored while auto_timing_sense is high.
// - with auto_timing_sense low, processing allowed and the trs mask control bit clear, a high f input sets the f bit of every outgoing trs word.
// - the f input is ignored while auto_timing_sense is high.
`timescale 1ns/1ps
`default_nettype none
module trs_timing_flag_insertion (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    input  wire trs_flag_pkg::video_word_s   vid_in,
    input  wire trs_flag_pkg::timing_flags_s timing_in,
    input  wire logic                        auto_timing_sense,
    input  wire logic                        processing_allow_pin,
    input  wire trs_flag_pkg::reg_req_s      reg_req,
    output logic [15:0]                      reg_rdata,
    output trs_flag_pkg::video_word_s        vid_out
);
    import trs_flag_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [9:0] build_flag_word(input timing_flags_s fl);
        logic [9:0] w;
        w                = 10'h000;
        w[XYZ_ONE_BIT]   = 1'b1;
        w[XYZ_F_BIT]     = fl.f;
        w[XYZ_V_BIT]     = fl.v;
        w[XYZ_H_BIT]     = fl.h;
        w[XYZ_P3_BIT]    = fl.v ^ fl.h;
        w[XYZ_P2_BIT]    = fl.f ^ fl.h;
        w[XYZ_P1_BIT]    = fl.f ^ fl.v;
        w[XYZ_P0_BIT]    = fl.f ^ fl.v ^ fl.h;
        return w;
    endfunction : build_flag_word

    function automatic timing_flags_s flags_of(input logic [9:0] w);
        timing_flags_s fl;
        fl.f = w[XYZ_F_BIT];
        fl.v = w[XYZ_V_BIT];
        fl.h = w[XYZ_H_BIT];
        return fl;
    endfunction : flags_of

    // one decode for every write strobe, so a map change touches a single place
    function automatic logic write_hit(input reg_req_s rq, input logic [3:0] target);
        return rq.wr && (rq.addr == target);
    endfunction : write_hit

    // ****************************************
    // pin filters
    // ****************************************
    // both control pins are asynchronous; a level counts once stages two and three agree
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_s3;
    logic [1:0] pin_level;

    wire  [1:0] next_pin_level = (pin_s2 == pin_s3) ? pin_s3 : pin_level;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_s1    <= 2'h0;
            pin_s2    <= 2'h0;
            pin_s3    <= 2'h0;
            pin_level <= 2'h0;
        end else if (ce) begin
            pin_s1    <= {processing_allow_pin, auto_timing_sense};
            pin_s2    <= pin_s1;
            pin_s3    <= pin_s2;
            pin_level <= next_pin_level;
        end
    end

    wire sense_on  = pin_level[0];
    wire allow_on  = pin_level[1];

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] ctrl;
    logic [15:0] events;
    logic [15:0] trs_count;
    logic [15:0] rdata_q;
    timing_flags_s last_flags;

    wire wr_ctrl   = write_hit(reg_req, REG_CTRL);
    wire wr_events = write_hit(reg_req, REG_EVENTS);
    wire wr_count  = write_hit(reg_req, REG_TRS_CNT);

    wire [15:0] next_ctrl = reg_req.wdata & CTRL_WRITE_MASK;

    wire h_config  = ctrl[CTRL_H_CONFIG_BIT];
    wire trs_mask  = ctrl[CTRL_TRS_MASK_BIT];
    wire insert_on = !sense_on && allow_on && !trs_mask;

    // ****************************************
    // trs tracking
    // ****************************************
    logic preamble_start;
    logic flag_word;

    trs_word_tracker u_tracker (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .ce             (ce),
        .vid_in         (vid_in),
        .preamble_start (preamble_start),
        .flag_word      (flag_word)
    );

    // under the trs based convention h may move on the preamble, so it is taken at the first word
    logic h_at_preamble;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            h_at_preamble <= 1'b0;
        end else if (ce && preamble_start) begin
            h_at_preamble <= timing_in.h;
        end
    end

    // ****************************************
    // flag selection
    // ****************************************
    timing_flags_s rx_flags;
    timing_flags_s pin_flags;
    timing_flags_s out_flags;

    assign rx_flags    = flags_of(vid_in.data);
    assign pin_flags.f = timing_in.f;
    assign pin_flags.v = timing_in.v;
    assign pin_flags.h = h_config ? h_at_preamble : timing_in.h;
    // received flags win whenever sensing is on, so the pins are never looked at then
    assign out_flags   = insert_on ? pin_flags : rx_flags;

    wire [9:0] new_flag_word = build_flag_word(out_flags);
    wire       replace_word  = flag_word && insert_on;
    wire [9:0] next_data     = replace_word ? new_flag_word : vid_in.data;

    // ****************************************
    // video path
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            vid_out <= '0;
        end else if (ce) begin
            vid_out.valid <= vid_in.valid;
            vid_out.data  <= next_data;
        end
    end

    // ****************************************
    // mismatch events
    // ****************************************
    // a flag the source drives that disagrees with the received word hints at a timing slip
    wire [15:0] evt_set = {13'h0000,
                           flag_word && insert_on && (pin_flags.f != rx_flags.f),
                           flag_word && insert_on && (pin_flags.v != rx_flags.v),
                           flag_word && insert_on && (pin_flags.h != rx_flags.h)};
    wire [15:0] evt_clr = wr_events ? reg_req.wdata : REG_ZERO;
    // set wins over a clear in the same cycle
    wire [15:0] next_events = (events & ~evt_clr) | evt_set;

    wire [15:0] next_count = wr_count ? REG_ZERO :
                             (flag_word ? trs_count + 16'h0001 : trs_count);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (ce && wr_ctrl) begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            events <= REG_ZERO;
        end else if (ce) begin
            events <= next_events;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            trs_count <= REG_ZERO;
        end else if (ce) begin
            trs_count <= next_count;
        end
    end

    // last flags follow the word actually sent, whichever source won
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            last_flags <= '0;
        end else if (ce && flag_word) begin
            last_flags <= out_flags;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [15:0] status;

    always_comb begin
        status                  = REG_ZERO;
        status[STAT_SENSE_BIT]  = sense_on;
        status[STAT_ALLOW_BIT]  = allow_on;
        status[STAT_INSERT_BIT] = insert_on;
        status[STAT_F_BIT]      = last_flags.f;
        status[STAT_V_BIT]      = last_flags.v;
        status[STAT_H_BIT]      = last_flags.h;
    end

    logic [15:0] read_mux;

    always_comb begin
        unique case (reg_req.addr)
            REG_CTRL:    read_mux = ctrl;
            REG_STATUS:  read_mux = status;
            REG_EVENTS:  read_mux = events;
            REG_TRS_CNT: read_mux = trs_count;
            default:     read_mux = REG_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= REG_ZERO;
        end else if (ce) begin
            rdata_q <= reg_req.rd ? read_mux : REG_ZERO;
        end
    end

    assign reg_rdata = rdata_q;

endmodule : trs_timing_flag_insertion
`default_nettype wire

// [hdl/trs_flag_pkg.sv]
// package: constants and carriers for the trs timing flag insertion block
package trs_flag_pkg;

    // ****************************************
    // video word constants
    // ****************************************
    localparam int          WORD_W       = 10;
    localparam logic [9:0]  TRS_PREAMBLE_ONE  = 10'h3ff;
    localparam logic [9:0]  TRS_PREAMBLE_ZERO = 10'h000;
    localparam int          XYZ_ONE_BIT  = 9;
    localparam int          XYZ_F_BIT    = 8;
    localparam int          XYZ_V_BIT    = 7;
    localparam int          XYZ_H_BIT    = 6;
    localparam int          XYZ_P3_BIT   = 5;
    localparam int          XYZ_P2_BIT   = 4;
    localparam int          XYZ_P1_BIT   = 3;
    localparam int          XYZ_P0_BIT   = 2;

    // ****************************************
    // register map (word index on the plain register port)
    // ****************************************
    localparam int          REG_ADDR_W   = 4;
    localparam int          REG_DATA_W   = 16;
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h1;
    localparam logic [3:0]  REG_EVENTS   = 4'h2;
    localparam logic [3:0]  REG_TRS_CNT  = 4'h3;

    // control register fields
    localparam int          CTRL_H_CONFIG_BIT = 0;
    localparam int          CTRL_TRS_MASK_BIT = 1;
    localparam logic [15:0] CTRL_RESET        = 16'h0000;
    localparam logic [15:0] CTRL_WRITE_MASK   = 16'h0003;

    // status register fields
    localparam int          STAT_SENSE_BIT    = 0;
    localparam int          STAT_ALLOW_BIT    = 1;
    localparam int          STAT_INSERT_BIT   = 2;
    localparam int          STAT_F_BIT        = 3;
    localparam int          STAT_V_BIT        = 4;
    localparam int          STAT_H_BIT        = 5;

    // event register fields (write one to clear)
    localparam int          EVT_H_MISMATCH_BIT = 0;
    localparam int          EVT_V_MISMATCH_BIT = 1;
    localparam int          EVT_F_MISMATCH_BIT = 2;

    localparam logic [15:0] REG_ZERO     = 16'h0000;

    // ****************************************
    // pin filter depth
    // ****************************************
    localparam int          PIN_SYNC_STAGES = 3;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic       valid;
        logic [9:0] data;
    } video_word_s;

    typedef struct packed {
        logic f;
        logic v;
        logic h;
    } timing_flags_s;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

endpackage : trs_flag_pkg

// [hdl/trs_word_tracker.sv]
// trs word tracker: finds the preamble and marks the flag word of each timing reference
`timescale 1ns/1ps
`default_nettype none
module trs_word_tracker (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    input  wire trs_flag_pkg::video_word_s vid_in,
    output logic                           preamble_start,
    output logic                           flag_word
);
    import trs_flag_pkg::*;

    // ****************************************
    // word history
    // ****************************************
    typedef enum logic [1:0] {
        SEEK     = 2'b00,
        SAW_ONES = 2'b01,
        SAW_ZERO = 2'b10,
        SAW_BOTH = 2'b11
    } trs_seek_e;

    trs_seek_e state;
    trs_seek_e next_state;

    wire is_ones = vid_in.data == TRS_PREAMBLE_ONE;
    wire is_zero = vid_in.data == TRS_PREAMBLE_ZERO;

    always_comb begin
        next_state = state;
        unique case (state)
            SEEK:     next_state = is_ones ? SAW_ONES : SEEK;
            SAW_ONES: next_state = is_zero ? SAW_ZERO : (is_ones ? SAW_ONES : SEEK);
            SAW_ZERO: next_state = is_zero ? SAW_BOTH : (is_ones ? SAW_ONES : SEEK);
            SAW_BOTH: next_state = is_ones ? SAW_ONES : SEEK;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= SEEK;
        end else if (ce && vid_in.valid) begin
            state <= next_state;
        end
    end

    // the flag word is the one that follows ones, zero, zero; a run of ones restarts the search
    assign preamble_start = vid_in.valid && is_ones && (state != SAW_ONES);
    assign flag_word      = vid_in.valid && (state == SAW_BOTH);

endmodule : trs_word_tracker
`default_nettype wire

// [tb/trs_flag_chk.sv]
// checker: port assertions for the trs timing flag insertion block
`timescale 1ns/1ps
`default_nettype none
module trs_flag_chk (
    input wire logic                        ref_clk,
    input wire logic                        rst_n,
    input wire logic                        ce,
    input wire trs_flag_pkg::video_word_s   vid_in,
    input wire trs_flag_pkg::timing_flags_s timing_in,
    input wire logic                        auto_timing_sense,
    input wire logic                        processing_allow_pin,
    input wire trs_flag_pkg::reg_req_s      reg_req,
    input wire logic [15:0]                 reg_rdata,
    input wire trs_flag_pkg::video_word_s   vid_out
);
    import trs_flag_pkg::*;
    // ****************************************
    // helper state
    // ****************************************
    logic [29:0] hist;
    logic [3:0]  calm;
    logic        hcfg;
    logic        mask;
    logic        h_pre;
    wire         is_flag = ce && vid_in.valid && hist == {TRS_PREAMBLE_ONE, TRS_PREAMBLE_ZERO, TRS_PREAMBLE_ZERO};
    wire         settled = calm == 4'hf;
    wire         ins     = settled && !auto_timing_sense && processing_allow_pin && !mask;
    wire         h_exp   = hcfg ? h_pre : timing_in.h;
    wire [9:0]   w       = vid_out.data;
    // pins pass a filter, so flags are only judged once both pins stood still
    always_ff @(posedge ref_clk) begin
        if (!rst_n || $changed(auto_timing_sense) || $changed(processing_allow_pin)) begin
            calm <= 4'h0;
        end else if (ce && !settled) begin
            calm <= calm + 4'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hist  <= '0;
            hcfg  <= 1'b0;
            mask  <= 1'b0;
            h_pre <= 1'b0;
        end else if (ce) begin
            if (vid_in.valid) hist <= {hist[19:0], vid_in.data};
            if (vid_in.valid && vid_in.data == TRS_PREAMBLE_ONE) h_pre <= timing_in.h;
            if (reg_req.wr && reg_req.addr == REG_CTRL) {mask, hcfg} <= reg_req.wdata[1:0];
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    reset_clear_a: assert property (disable iff (1'b0) !rst_n && ce |=> vid_out == '0 && reg_rdata == REG_ZERO)
        else $error("outputs not cleared by reset");
    read_idle_a: assert property (ce && !reg_req.rd |=> reg_rdata == REG_ZERO)
        else $error("read data outside its slot");
    unmapped_a: assert property (ce && reg_req.rd && reg_req.addr > REG_TRS_CNT |=> reg_rdata == REG_ZERO)
        else $error("unmapped read not zero");
    pass_word_a: assert property (ce && !is_flag |=> vid_out == $past(vid_in))
        else $error("non flag word altered");
    ignore_pins_a: assert property (is_flag && settled && !ins |=> vid_out == $past(vid_in))
        else $error("flag word altered while insertion off");
    flag_form_a: assert property (is_flag && ins |=> vid_out.valid && w[9] && w[1:0] == 2'b00 &&
        w[5:2] == {w[7] ^ w[6], w[8] ^ w[6], w[8] ^ w[7], ^w[8:6]}) else $error("flag word badly formed");
    f_insert_a: assert property (is_flag && ins |=> w[XYZ_F_BIT] == $past(timing_in.f))
        else $error("f flag not taken from pin");
    v_insert_a: assert property (is_flag && ins |=> w[XYZ_V_BIT] == $past(timing_in.v))
        else $error("v flag not taken from pin");
    h_insert_a: assert property (is_flag && ins |=> w[XYZ_H_BIT] == $past(h_exp))
        else $error("h flag not taken from pin");
endmodule : trs_flag_chk
bind trs_timing_flag_insertion trs_flag_chk u_chk (.ref_clk, .rst_n, .ce, .vid_in, .timing_in,
    .auto_timing_sense, .processing_allow_pin, .reg_req, .reg_rdata, .vid_out);
`default_nettype wire

// [tb/trs_src.sv]
// partner: upstream source emitting one timing reference per start pulse
`timescale 1ns/1ps
`default_nettype none
module trs_src (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        start,
    input  wire trs_flag_pkg::timing_flags_s tf,
    input  wire trs_flag_pkg::timing_flags_s rx,
    input  wire logic                        h_flip,
    output trs_flag_pkg::video_word_s        vid,
    output trs_flag_pkg::timing_flags_s      tim,
    output logic                             flag_now
);
    import trs_flag_pkg::*;
    logic [2:0] step;
    logic [9:0] pat;
    wire  [9:0] xyz  = {1'b1, rx.f, rx.v, rx.h, rx.v ^ rx.h, rx.f ^ rx.h, rx.f ^ rx.v, ^rx, 2'b00};
    // idle words are invalid and keep changing so no stale value looks settled
    wire  [9:0] word = step == 3'd0 ? pat : step == 3'd1 ? TRS_PREAMBLE_ONE : step == 3'd4 ? xyz : TRS_PREAMBLE_ZERO;
    assign vid      = {step != 3'd0, word};
    assign flag_now = step == 3'd4;
    // levels held over the whole sequence; h_flip breaks h at the flag word on purpose
    assign tim      = {tf.f, tf.v, tf.h ^ (flag_now & h_flip)};
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            step <= 3'd0;
            pat  <= 10'h000;
        end else begin
            pat  <= pat + 10'h133;
            step <= step == 3'd4 ? 3'd0 : (step != 3'd0 || start) ? step + 3'd1 : step;
        end
    end
endmodule : trs_src
`default_nettype wire

// [tb/trs_timing_flag_insertion_bench.sv]
// bench: random and corner traffic through the trs timing flag insertion block
`timescale 1ns/1ps
`default_nettype none
module trs_timing_flag_insertion_bench;
    import trs_flag_pkg::*;
    logic          ref_clk = 1'b0;
    logic          rst_n   = 1'b0;
    logic          ce      = 1'b1;
    logic          sense   = 1'b0;
    logic          allow   = 1'b0;
    logic          start   = 1'b0;
    logic          h_flip  = 1'b0;
    timing_flags_s tf      = '0;
    timing_flags_s rx      = '0;
    reg_req_s      req     = '0;
    logic [15:0]   ctrl    = 16'h0000;
    video_word_s   vid_in;
    video_word_s   vid_out;
    timing_flags_s tim;
    logic [15:0]   rdata;
    logic          flag_now;
    logic [15:0]   got;
    video_word_s   snap;
    int            bad_count  = 0;
    int            n_compared = 0;
    int            seed       = 94266;
    int            sent       = 0;
`define CHECK(what, exp, act) begin n_compared++; if ((act) !== (exp)) begin bad_count++; \
    $display("Error %s expected %h seen %h", what, exp, act); end end
    always #4 ref_clk = ~ref_clk;
    trs_src src (.ref_clk, .rst_n, .start, .tf, .rx, .h_flip, .vid(vid_in), .tim, .flag_now);
    trs_timing_flag_insertion dut (.ref_clk, .rst_n, .ce, .vid_in, .timing_in(tim), .auto_timing_sense(sense),
        .processing_allow_pin(allow), .reg_req(req), .reg_rdata(rdata), .vid_out);
    // ****************************************
    // tasks
    // ****************************************
    function automatic video_word_s exp_word(input timing_flags_s t);
        return {2'b11, t.f, t.v, t.h, t.v ^ t.h, t.f ^ t.h, t.f ^ t.v, ^t, 2'b00};
    endfunction : exp_word
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req <= '0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req <= '0;
        #1 got = rdata;
    endtask : reg_rd
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // r holds flip, pin flags and received flags; the expected flags follow the insertion state
    task automatic trs(input logic [6:0] r, input logic s, input logic a);
        timing_flags_s e;
        logic          act;
        int            i;
        @(posedge ref_clk);
        tf     <= r[5:3];
        rx     <= r[2:0];
        h_flip <= r[6];
        sense  <= s;
        allow  <= a;
        repeat (16) @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        act = !s && a && !ctrl[1];
        e   = act ? r[5:3] : r[2:0];
        if (act && !ctrl[0]) e.h = r[3] ^ r[6];
        for (i = 0; i < 20 && flag_now !== 1'b1; i++) @(negedge ref_clk);
        `CHECK("flag wait", 1'b1, flag_now)
        if (flag_now !== 1'b1) tally_and_finish();
        @(negedge ref_clk);
        `CHECK("flag word", exp_word(e), vid_out)
        sent++;
        reg_rd(REG_STATUS);
        `CHECK("status", {e.h, e.v, e.f, act, a, s}, got[5:0])
        reg_rd(REG_EVENTS);
        `CHECK("events", {13'h0000, act && (e.f != r[2]), act && (e.v != r[1]), act && (e.h != r[0])}, got)
        reg_wr(REG_EVENTS, 16'h0007);
    endtask : trs
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        reg_wr(4'hf, 16'hffff);
        reg_rd(REG_CTRL);
        `CHECK("ctrl reset", CTRL_RESET, got)
        reg_rd(4'h9);
        `CHECK("unmapped read", REG_ZERO, got)
        for (int k = 0; k < 4; k++) begin
            ctrl = 16'(k);
            reg_wr(REG_CTRL, ctrl);
            reg_rd(REG_CTRL);
            `CHECK("ctrl", ctrl, got)
            trs(7'h7f, 1'b0, 1'b1);
            trs(7'h47, 1'b0, 1'b1);
            repeat (12) trs(7'($random(seed)), &2'($random(seed)), |2'($random(seed)));
        end
        // clock enable low must hold the output word while the source keeps moving
        @(posedge ref_clk);
        ce <= 1'b0;
        @(negedge ref_clk);
        snap = vid_out;
        repeat (4) @(negedge ref_clk);
        `CHECK("ce freeze", snap, vid_out)
        @(posedge ref_clk);
        ce <= 1'b1;
        reg_rd(REG_TRS_CNT);
        `CHECK("trs count", 16'(sent), got)
        reg_wr(REG_TRS_CNT, 16'h1234);
        reg_rd(REG_TRS_CNT);
        `CHECK("count cleared", REG_ZERO, got)
        tally_and_finish();
    end
endmodule : trs_timing_flag_insertion_bench
`default_nettype wire
